// ==== common/ntc_params.svh ====
// constants for the numeric type converter
`ifndef NTC_PARAMS_SVH
`define NTC_PARAMS_SVH

// floating-point field layout
`define NTC_EXP_BIAS     8'h7f
`define NTC_EXP_SPECIAL  8'hff
`define NTC_MANT_BITS    24
`define NTC_MAX_SHIFT    8'h1f

// decimal limits
`define NTC_BCD_MAX      16'h270f
`define NTC_DIGIT_MAX    4'h9
`define NTC_BCD_DIGITS   4

// reset values of the result registers
`define NTC_RES16_RST    16'h0000
`define NTC_RES32_RST    32'h0000_0000

// result latency in clock cycles
`define NTC_LATENCY      1

`endif

// ==== common/ntc_pkg.sv ====
// types shared by the numeric type converter
package ntc_pkg;

  // source format of the signed-integer operation
  typedef enum logic {
    NTC_SRC_BCD  = 1'b0,
    NTC_SRC_REAL = 1'b1
  } ntc_src_t;

  // integer width selection
  typedef enum logic {
    NTC_W16 = 1'b0,
    NTC_W32 = 1'b1
  } ntc_width_t;

endpackage

// ==== core/ntc_converter.sv ====
// numeric type converter: six registered conversion paths
`timescale 1ns/10ps
`default_nettype none
`include "ntc_params.svh"

module ntc_converter
  import ntc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // integer to bcd
  input  wire logic        bcd_en,
  input  wire logic [15:0] bcd_src,
  output var  logic [15:0] bcd_res,
  output var  logic        bcd_ok,
  // bcd or real to signed integer
  input  wire logic        int_en,
  input  wire ntc_src_t    int_sel,
  input  wire logic [31:0] int_src,
  output var  logic [15:0] int_res,
  output var  logic        int_ok,
  // real to double_width_signed
  input  wire logic        dws_en,
  input  wire logic [31:0] dws_src,
  output var  logic [31:0] dws_res,
  output var  logic        dws_ok,
  // integer to real
  input  wire logic        real_en,
  input  wire ntc_width_t  real_width,
  input  wire logic [31:0] real_src,
  output var  logic [31:0] real_res,
  output var  logic        real_ok,
  // real to word
  input  wire logic        word_en,
  input  wire logic [31:0] word_src,
  output var  logic [15:0] word_res,
  output var  logic        word_ok,
  // truncate_toward_zero_op
  input  wire logic        trunc_en,
  input  wire ntc_width_t  trunc_width,
  input  wire logic [31:0] trunc_src,
  output var  logic [31:0] trunc_res,
  output var  logic        trunc_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // shared arithmetic
  // real to integer, toward zero; 42 bits so every overflow stays visible
  function automatic logic signed [41:0] real_trunc(input logic [31:0] r);
    logic [7:0]  e;
    logic [63:0] t;
    logic [40:0] m;
    begin
      e = r[30:23];
      t = 64'h0;
      m = 41'h0;
      if (e >= `NTC_EXP_BIAS) begin
        if (e > `NTC_EXP_BIAS + `NTC_MAX_SHIFT) begin
          m = {1'b1, 40'h0};
        end else begin
          t = {40'h0, 1'b1, r[22:0]} << (e - `NTC_EXP_BIAS);
          m = t[63:23];
        end
      end
      real_trunc = r[31] ? -$signed({1'b0, m}) : $signed({1'b0, m});
    end
  endfunction
  function automatic logic is_special(input logic [31:0] r);
    is_special = (r[30:23] == `NTC_EXP_SPECIAL);
  endfunction
  function automatic logic fits16(input logic signed [41:0] v);
    fits16 = (&v[41:15]) | ~(|v[41:15]);
  endfunction
  function automatic logic fits32(input logic signed [41:0] v);
    fits32 = (&v[41:31]) | ~(|v[41:31]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // conversion results (combinational)
  logic [15:0]        bcd_enc;
  logic [15:0]        bcd_dec;
  logic               bcd_digits_ok;
  logic signed [41:0] int_tr;
  logic signed [41:0] dws_tr;
  logic signed [41:0] word_tr;
  logic signed [41:0] trunc_tr;
  logic [31:0]        flt_in;
  logic [31:0]        flt_out;

  always_comb begin
    logic [15:0] x;
    x = bcd_src;
    bcd_enc = 16'h0;
    for (int i = 0; i < `NTC_BCD_DIGITS; i++) begin
      bcd_enc[i*4 +: 4] = 4'(x % 16'd10);
      x = x / 16'd10;
    end
  end
  always_comb begin
    bcd_dec = 16'h0;
    bcd_digits_ok = 1'b1;
    for (int i = `NTC_BCD_DIGITS - 1; i >= 0; i--) begin
      if (int_src[i*4 +: 4] > `NTC_DIGIT_MAX) begin
        bcd_digits_ok = 1'b0;
      end
      bcd_dec = 16'(bcd_dec * 16'd10) + {12'h0, int_src[i*4 +: 4]};
    end
  end
  assign int_tr   = real_trunc(int_src);
  assign dws_tr   = real_trunc(dws_src);
  assign word_tr  = real_trunc(word_src);
  assign trunc_tr = real_trunc(trunc_src);
  // 16-bit sources are sign extended before conversion
  assign flt_in = (real_width == NTC_W32) ? real_src
                                          : {{16{real_src[15]}}, real_src[15:0]};
  // integer to real, round to nearest even on the 24-bit mantissa
  always_comb begin
    logic [31:0] mag;
    logic [31:0] norm;
    logic [4:0]  lead;
    logic [24:0] sum;
    logic        rnd;
    mag  = flt_in[31] ? 32'(-flt_in) : flt_in;
    lead = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) begin
        lead = 5'(i);
      end
    end
    norm = mag << (5'd31 - lead);
    rnd  = norm[7] & ((|norm[6:0]) | norm[8]);
    sum  = {1'b0, norm[31:8]} + {24'h0, rnd};
    if (mag == 32'h0) begin
      flt_out = 32'h0;
    end else if (sum[24]) begin
      flt_out = {flt_in[31], 8'(`NTC_EXP_BIAS + {3'h0, lead} + 8'h1), sum[23:1]};
    end else begin
      flt_out = {flt_in[31], 8'(`NTC_EXP_BIAS + {3'h0, lead}), sum[22:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result registers: a failed or idle cycle keeps the last good result
  // operands are only read here, never written back
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bcd_res <= `NTC_RES16_RST;
      bcd_ok  <= 1'b0;
    end else begin
      bcd_ok <= 1'b0;
      if (bcd_en && !bcd_src[15] && bcd_src <= `NTC_BCD_MAX) begin
        bcd_res <= bcd_enc;
        bcd_ok  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_res <= `NTC_RES16_RST;
      int_ok  <= 1'b0;
    end else begin
      int_ok <= 1'b0;
      if (int_en) begin
        if (int_sel == NTC_SRC_BCD) begin
          if (bcd_digits_ok) begin
            int_res <= bcd_dec;
            int_ok  <= 1'b1;
          end
        end else if (!is_special(int_src) && fits16(int_tr)) begin
          int_res <= int_tr[15:0];
          int_ok  <= 1'b1;
        end
      end
    end
  end

  // low mantissa bits of large reals are already gone: only 24 significant bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dws_res <= `NTC_RES32_RST;
      dws_ok  <= 1'b0;
    end else begin
      dws_ok <= 1'b0;
      if (dws_en && !is_special(dws_src) && fits32(dws_tr)) begin
        dws_res <= dws_tr[31:0];
        dws_ok  <= 1'b1;
      end
    end
  end

  // every 32-bit integer has a real form, so no error case exists here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      real_res <= `NTC_RES32_RST;
      real_ok  <= 1'b0;
    end else begin
      real_ok <= real_en;
      if (real_en) begin
        real_res <= flt_out;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_res <= `NTC_RES16_RST;
      word_ok  <= 1'b0;
    end else begin
      word_ok <= 1'b0;
      if (word_en && !is_special(word_src) && word_tr[41:16] == 26'h0) begin
        word_res <= word_tr[15:0];
        word_ok  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trunc_res <= `NTC_RES32_RST;
      trunc_ok  <= 1'b0;
    end else begin
      trunc_ok <= 1'b0;
      if (trunc_en && !is_special(trunc_src)) begin
        if (trunc_width == NTC_W32 && fits32(trunc_tr)) begin
          trunc_res <= trunc_tr[31:0];
          trunc_ok  <= 1'b1;
        end else if (trunc_width == NTC_W16 && fits16(trunc_tr)) begin
          trunc_res <= {{16{trunc_tr[15]}}, trunc_tr[15:0]};
          trunc_ok  <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_bcd_range_fail: assert property (bcd_en && bcd_src > 16'h270f |=> !bcd_ok)
    else $error("bcd ok raised out of range");
  a_bcd_digit_value: assert property (bcd_en && bcd_src == 16'h04d2
    |=> bcd_ok && bcd_res == 16'h1234)
    else $error("bcd encoding wrong");
  a_int_idle_low: assert property (!int_en |=> !int_ok)
    else $error("int ok without enable");
  a_int_bad_digit: assert property (int_en && int_sel == NTC_SRC_BCD
    && int_src[3:0] > 4'h9 |=> !int_ok && $stable(int_res))
    else $error("bad bcd digit accepted");
  a_int_nan_fail: assert property (int_en && int_sel == NTC_SRC_REAL
    && int_src[30:23] == 8'hff |=> !int_ok)
    else $error("int ok on nan");
  a_dws_range_fail: assert property (dws_en && dws_src[30:23] > 8'h9e |=> !dws_ok)
    else $error("wide ok out of range");
  a_real_round_even: assert property (real_en && real_width == NTC_W32
    && real_src == 32'h01000001 |=> real_ok && real_res == 32'h4b800000)
    else $error("real rounding wrong");
  a_real_sign_extend: assert property (real_en && real_width == NTC_W16
    && real_src[15:0] == 16'hffff |=> real_res == 32'hbf800000)
    else $error("16-bit source not sign extended");
  a_real_ok_follow: assert property (real_en |=> real_ok
    ##1 (real_ok == $past(real_en)))
    else $error("real ok does not follow enable");
  a_word_neg_fail: assert property (word_en && word_src[31]
    && word_src[30:23] >= 8'h7f |=> !word_ok)
    else $error("word ok on negative value");
  a_trunc_toward_zero: assert property (trunc_en && trunc_width == NTC_W32
    && trunc_src == 32'hbfc00000 |=> trunc_ok && trunc_res == 32'hffffffff)
    else $error("truncation not toward zero");
  a_trunc_narrow_fail: assert property (trunc_en && trunc_width == NTC_W16
    && trunc_src == 32'h47000000 |=> !trunc_ok && $stable(trunc_res))
    else $error("16-bit truncation accepted 32768");
  c_bcd_ok: cover property (bcd_en ##1 bcd_ok);
  c_int_from_bcd: cover property (int_en && int_sel == NTC_SRC_BCD ##1 int_ok);
  c_trunc_fail: cover property (trunc_en ##1 !trunc_ok);
  c_real_round_up: cover property (real_en && flt_out[22:0] == 23'h0 && real_src[7:0] != 8'h0);
endmodule

`default_nettype wire

// ==== sim/ntc_engine.sv ====
// program engine model issuing one conversion request per cycle
`timescale 1ns/10ps
`default_nettype none

module ntc_engine
  import ntc_pkg::*;
(
  // clock
  input  wire logic        clk,
  // request to the converter
  output var  logic [5:0]  en,
  output var  logic        sel,
  output var  logic [31:0] src
);
  initial begin
    en  = 6'h00;
    sel = 1'b0;
    src = 32'h0000_0000;
  end

  // one enable at a time, held until the next request or idle
  task automatic issue(input int p, input logic s, input logic [31:0] v);
    @(posedge clk);
    en  <= 6'h01 << p;
    sel <= s;
    src <= v;
  endtask

  // operand is inverted once per idle call so stray conversions show up
  task automatic idle();
    @(posedge clk);
    en  <= 6'h00;
    src <= ~src;
  endtask
endmodule

`default_nettype wire

// ==== sim/numeric_type_converter_tb.sv ====
// self-checking bench for the numeric type converter
`timescale 1ns/10ps
`default_nettype none

module numeric_type_converter_tb;
  import ntc_pkg::*;

  typedef struct packed {
    logic [2:0]  p;
    logic        ok;
    logic [31:0] res;
  } ntc_note_t;

  logic        clk = 1'b0;
  logic        sys_rst;
  wire  [5:0]  en;
  wire         sel;
  wire  [31:0] src;
  wire  [5:0]  okv;
  wire  [15:0] r0, r1, r4;
  wire  [31:0] r2, r3, r5;
  logic [5:0]  taken = 6'h00;
  logic [31:0] last [6];
  ntc_note_t   notes [$];
  ntc_note_t   note;
  int          bad_count, checks_done, cyc, i, d;
  logic [15:0] w;

  always #5 clk = ~clk;

  ntc_engine i_eng (.clk(clk), .en(en), .sel(sel), .src(src));

  ntc_converter i_dut (
    .clk(clk), .sys_rst(sys_rst),
    .bcd_en(en[0]), .bcd_src(src[15:0]), .bcd_res(r0), .bcd_ok(okv[0]),
    .int_en(en[1]), .int_sel(ntc_src_t'(sel)), .int_src(src), .int_res(r1), .int_ok(okv[1]),
    .dws_en(en[2]), .dws_src(src), .dws_res(r2), .dws_ok(okv[2]),
    .real_en(en[3]), .real_width(ntc_width_t'(sel)), .real_src(src), .real_res(r3),
    .real_ok(okv[3]),
    .word_en(en[4]), .word_src(src), .word_res(r4), .word_ok(okv[4]),
    .trunc_en(en[5]), .trunc_width(ntc_width_t'(sel)), .trunc_src(src), .trunc_res(r5),
    .trunc_ok(okv[5])
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] bcd4(input int n);
    bcd4 = {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
  endfunction

  function automatic logic [31:0] pick(input logic [2:0] p);
    case (p)
      3'h0: pick = {16'h0000, r0};
      3'h1: pick = {16'h0000, r1};
      3'h2: pick = r2;
      3'h3: pick = r3;
      3'h4: pick = {16'h0000, r4};
      default: pick = r5;
    endcase
  endfunction

  task automatic fail_msg(input logic [31:0] got, input logic [31:0] exp);
    bad_count++;
    $display("mismatch %0t got %h expected %h", $time, got, exp);
  endtask

  task automatic cmp_ok(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) fail_msg(32'(got), 32'(exp));
  endtask

  task automatic cmp_res(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) fail_msg(got, exp);
  endtask

  // failed conversions expect the last good result to stay
  task automatic run(input int p, input logic s, input logic [31:0] v,
                     input logic ok, input logic [31:0] r);
    ntc_note_t n;
    if (ok) last[p] = r;
    n.p = 3'(p);
    n.ok = ok;
    n.res = last[p];
    notes.push_back(n);
    i_eng.issue(p, s, v);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) taken <= en;

  always @(negedge clk) begin
    if (!sys_rst) begin
      if (taken == 6'h00) begin
        cmp_ok(okv, 6'h00);
      end else begin
        note = notes.pop_front();
        cmp_ok(okv, note.ok ? taken : 6'h00);
        cmp_res(pick(note.p), note.res);
      end
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      bad_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    bad_count = 0;
    checks_done = 0;
    cyc = 0;
    for (i = 0; i < 6; i++) last[i] = 32'h0000_0000;
    void'($urandom(32'h7b500654));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 16; i++) begin
      d = $urandom % 10000;
      run(0, 1'b0, 32'(d), 1'b1, 32'(bcd4(d)));
    end
    run(0, 1'b0, 32'h0000_270f, 1'b1, 32'h0000_9999);
    run(0, 1'b0, 32'h0000_2710, 1'b0, 32'h0);
    run(0, 1'b0, {17'h1, 15'($urandom)}, 1'b0, 32'h0);
    run(0, 1'b0, 32'h0000_0000, 1'b1, 32'h0000_0000);
    run(0, 1'b0, 32'h0000_04d2, 1'b1, 32'h0000_1234);
    for (i = 0; i < 12; i++) begin
      d = $urandom % 10000;
      w = bcd4(d);
      run(1, 1'b0, {16'($urandom), w}, 1'b1, 32'(d));
    end
    run(1, 1'b0, {16'h0, w[15:4], 4'ha + 4'($urandom % 6)}, 1'b0, 32'h0);
    run(1, 1'b0, 32'h0000_a000, 1'b0, 32'h0);
    run(1, 1'b1, 32'hc40c_b000, 1'b1, 32'h0000_fdce);
    run(1, 1'b1, 32'hc700_0000, 1'b1, 32'h0000_8000);
    run(1, 1'b1, 32'h4700_0000, 1'b0, 32'h0);
    run(1, 1'b1, 32'h7fc0_0000, 1'b0, 32'h0);
    i_eng.idle();
    run(2, 1'b0, 32'h440c_b000, 1'b1, 32'h0000_0232);
    run(2, 1'b0, 32'hcf00_0000, 1'b1, 32'h8000_0000);
    run(2, 1'b0, 32'h4f00_0000, 1'b0, 32'h0);
    run(2, 1'b0, 32'h4f80_0000, 1'b0, 32'h0);
    run(2, 1'b0, 32'h7fc0_0000, 1'b0, 32'h0);
    run(3, 1'b0, 32'ha5a5_ffff, 1'b1, 32'hbf80_0000);
    run(3, 1'b1, 32'h0000_02a6, 1'b1, 32'h4429_8000);
    run(3, 1'b1, 32'h0100_0001, 1'b1, 32'h4b80_0000);
    run(3, 1'b1, 32'h0100_0003, 1'b1, 32'h4b80_0002);
    run(4, 1'b0, 32'h477f_ff00, 1'b1, 32'h0000_ffff);
    run(4, 1'b0, 32'h4780_0000, 1'b0, 32'h0);
    run(4, 1'b0, 32'hbf00_0000, 1'b1, 32'h0000_0000);
    run(4, 1'b0, 32'hc40c_b000, 1'b0, 32'h0);
    i_eng.idle();
    run(5, 1'b1, 32'h4788_b800, 1'b1, 32'h0001_1170);
    run(5, 1'b0, 32'h4788_b800, 1'b0, 32'h0);
    run(5, 1'b0, 32'hc40c_b000, 1'b1, 32'hffff_fdce);
    run(5, 1'b1, 32'hbfc0_0000, 1'b1, 32'hffff_ffff);
    run(5, 1'b0, 32'h4700_0000, 1'b0, 32'h0);
    run(5, 1'b1, 32'h7fc0_0000, 1'b0, 32'h0);
    i_eng.idle();
    repeat (4) @(posedge clk);
    if (notes.size() != 0) fail_msg(32'(notes.size()), 32'h0);
    stop_test();
  end
endmodule

`default_nettype wire
